// >>> qsi_core.sv
// per-channel interrupt status, mask, queues, bid and compare registers
// assumes receiver, transmitter and arbiter logic on clk_sys; pins are async
//
// Operation
// - set status with set mask requests interrupt
// - masked-read mode returns status AND mask
// - input pin change sets bit 7, pin read clears
// - watchdog over 64 bit times sets bit 6
// - push or queue read clears watchdog status
// - address match sets bit 5, command clears
// - flow character sets bit 4, flow read clears
// - bit 3 reserved, reads zero
// - break start or end sets bit 2
// - trigger 00: ready while queue holds data
// - full trigger: ready only while queue full
// - half and three-quarter: ready at threshold
// - empty receive queue never requests service
// - transmit ready: empty, or below trigger
// - unmasked set source drives request low
// - receive queue 11 bits by 16, status top
// - head status shown in channel status register
// - block mode accumulates errors until reset command
// - transmit queue 8 bits by 16
// - four bid registers, low 3 bits
// - resume, pause and station compare registers
// - flow field held until flow status read
//
// Decided for this implementation: the address-and-strobe port and the register addresses.

`timescale 1ns/1ps

module qsi_core
   import qsi_pkg::*;
#(
   parameter int NCH       = 4,
   parameter int DEPTH     = 16,
   parameter int WDOG_BITS = WDOG_BIT_TIMES
)
(
   input  wire logic                    clk_sys,
   input  wire logic                    rst,
   input  wire logic [7:0]              bus_addr,
   input  wire logic [7:0]              bus_wdata,
   input  wire logic                    bus_wr,
   input  wire logic                    bus_rd,
   output logic [RD_W-1:0]              rd_data_ff,
   input  wire logic [NCH-1:0]          rx_push,
   input  wire qsi_rx_ent_t [NCH-1:0]   rx_entry,
   input  wire logic [NCH-1:0]          rx_addr_seen,
   input  wire logic [NCH-1:0]          rx_break,
   input  wire logic [NCH-1:0]          bit_tick,
   input  wire logic [NCH-1:0]          tx_pop,
   input  wire logic [NCH-1:0]          change_input_zero,
   input  wire logic [NCH-1:0]          change_input_one,
   output logic [NCH-1:0]               rx_room_ff,
   output logic [NCH-1:0]               tx_valid_ff,
   output logic [NCH-1:0][7:0]          tx_data_ff,
   output logic                         interrupt_request_low_ff
);

   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(NCH);
   localparam int WW = $clog2(WDOG_BITS + 2);
   localparam logic [AW:0]   CNT_FULL = (AW+1)'(DEPTH);
   localparam logic [WW-1:0] WD_TOP   = WW'(WDOG_BITS + 1);

   qsi_rx_ent_t        rxq_ff    [NCH][DEPTH];
   logic [7:0]         txq_ff    [NCH][DEPTH];
   logic [AW-1:0]      rx_wp_ff  [NCH];
   logic [AW-1:0]      rx_rp_ff  [NCH];
   logic [AW:0]        rx_cnt_ff [NCH];
   logic [AW-1:0]      tx_wp_ff  [NCH];
   logic [AW-1:0]      tx_rp_ff  [NCH];
   logic [AW:0]        tx_cnt_ff [NCH];
   logic [4:0]         sticky_ff [NCH];
   logic [7:0]         mask_ff   [NCH];
   logic [7:0]         mode_ff   [NCH];
   logic [2:0]         bid_ff    [NCH][4];
   logic [7:0]         cmp_ff    [NCH][3];
   logic [1:0]         flow_ff   [NCH];
   logic [2:0]         err_ff    [NCH];
   logic [WW-1:0]      wd_ff     [NCH];
   logic [1:0]         pin_s1_ff [NCH];
   logic [1:0]         pin_s2_ff [NCH];
   logic [1:0]         pin_s3_ff [NCH];
   logic [NCH-1:0]     brk_d_ff;
   logic [2:0]         pin_arm_ff;

   logic [CW-1:0]      sel_ch;
   logic [3:0]         sel_reg;
   logic               wr_loc;
   logic               rd_loc;
   logic               rd_glob;
   logic [NCH-1:0]     rx_in;
   logic [NCH-1:0]     rx_pop;
   logic [NCH-1:0]     tx_in;
   logic [NCH-1:0]     tx_out;
   logic [AW:0]        nxt_rx_cnt [NCH];
   logic [AW:0]        nxt_tx_cnt [NCH];
   logic [AW-1:0]      nxt_tx_rp  [NCH];
   logic [NCH-1:0]     rx_rdy;
   logic [NCH-1:0]     tx_rdy;
   logic [7:0]         isr_now    [NCH];
   logic [4:0]         stk_set    [NCH];
   logic [4:0]         stk_clr    [NCH];
   logic [1:0]         flow_hit   [NCH];
   logic [NCH-1:0]     wd_ev;
   logic               any_req;
   logic [RD_W-1:0]    nxt_rd_data;

   assign sel_ch  = bus_addr[4 +: CW];
   assign sel_reg = bus_addr[3:0];
   assign wr_loc  = bus_wr && (bus_addr[7:6] == PAGE_LOCAL);
   assign rd_loc  = bus_rd && (bus_addr[7:6] == PAGE_LOCAL);
   assign rd_glob = bus_rd && (bus_addr[7:6] == PAGE_GLOBAL) && (sel_reg == OFF_RXQ);

   function automatic logic hit(input logic go, input logic [3:0] off, input int c);
      return go && (sel_reg == off) && (sel_ch == CW'(c));
   endfunction

   function automatic logic cmd_hit(input logic [4:0] code, input int c);
      return hit(wr_loc, OFF_CMD, c) && (bus_wdata[7:3] == code);
   endfunction

   // 00 data present, 01 half, 10 three quarters, 11 full
   function automatic logic rx_level(input logic [1:0] m, input logic [AW:0] n);
      case (m)
         2'h0:    return n != '0;
         2'h1:    return n >= (AW+1)'(DEPTH / 2);
         2'h2:    return n >= (AW+1)'((DEPTH * 3) / 4);
         default: return n == CNT_FULL;
      endcase
   endfunction

   // 00 only when empty, else below a quarter, half, three quarters
   function automatic logic tx_level(input logic [1:0] m, input logic [AW:0] n);
      case (m)
         2'h0:    return n == '0;
         2'h1:    return n < (AW+1)'(DEPTH / 4);
         2'h2:    return n < (AW+1)'(DEPTH / 2);
         default: return n < (AW+1)'((DEPTH * 3) / 4);
      endcase
   endfunction

   always_comb
   begin
      any_req = 1'b0;
      for (int c = 0; c < NCH; c++)
      begin
         rx_pop[c] = (hit(rd_loc, OFF_RXQ, c) || (rd_glob && sel_ch == CW'(c)))
                     && rx_cnt_ff[c] != '0;
         rx_in[c]  = rx_push[c] && rx_cnt_ff[c] != CNT_FULL;
         tx_in[c]  = hit(wr_loc, OFF_TXQ, c) && tx_cnt_ff[c] != CNT_FULL;
         tx_out[c] = tx_pop[c] && tx_valid_ff[c];
         nxt_rx_cnt[c] = rx_cnt_ff[c] + (AW+1)'(rx_in[c]) - (AW+1)'(rx_pop[c]);
         nxt_tx_cnt[c] = tx_cnt_ff[c] + (AW+1)'(tx_in[c]) - (AW+1)'(tx_out[c]);
         nxt_tx_rp[c]  = tx_rp_ff[c] + AW'(tx_out[c]);
         rx_rdy[c] = rx_level(mode_ff[c][MB_RXT +: 2], rx_cnt_ff[c]);
         tx_rdy[c] = tx_level(mode_ff[c][MB_TXT +: 2], tx_cnt_ff[c]);
         isr_now[c] = {sticky_ff[c][4:1], 1'b0, sticky_ff[c][SB_BRK],
                       rx_rdy[c], tx_rdy[c]};
         wd_ev[c] = rx_in[c] || rx_pop[c];
         flow_hit[c] = {rx_entry[c].data == cmp_ff[c][0],
                        rx_entry[c].data == cmp_ff[c][1]};
         if (!rx_in[c])
            flow_hit[c] = 2'h0;
         stk_set[c][SB_PIN]  = pin_arm_ff[2] && pin_s2_ff[c] != pin_s3_ff[c];
         stk_set[c][SB_WD]   = wd_ff[c] == WD_TOP && !wd_ev[c];
         stk_set[c][SB_ADDR] = rx_addr_seen[c]
                               && rx_entry[c].data == cmp_ff[c][2];
         stk_set[c][SB_FLOW] = |flow_hit[c];
         stk_set[c][SB_BRK]  = rx_break[c] != brk_d_ff[c];
         stk_clr[c][SB_PIN]  = hit(rd_loc, OFF_PINS, c);
         stk_clr[c][SB_WD]   = wd_ev[c];
         stk_clr[c][SB_ADDR] = cmd_hit(CMD_RST_ADDR, c);
         stk_clr[c][SB_FLOW] = hit(rd_loc, OFF_FLOW, c);
         stk_clr[c][SB_BRK]  = cmd_hit(CMD_RST_BRK, c);
         any_req = any_req || |(isr_now[c] & mask_ff[c]);
      end
   end

   // queue storage carries no reset; pointers and counts define contents
   always_ff @(posedge clk_sys)
   begin
      for (int c = 0; c < NCH; c++)
      begin
         if (rx_in[c])
            rxq_ff[c][rx_wp_ff[c]] <= rx_entry[c];
         if (tx_in[c])
            txq_ff[c][tx_wp_ff[c]] <= bus_wdata;
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         for (int c = 0; c < NCH; c++)
         begin
            rx_wp_ff[c]  <= '0;
            rx_rp_ff[c]  <= '0;
            rx_cnt_ff[c] <= '0;
            tx_wp_ff[c]  <= '0;
            tx_rp_ff[c]  <= '0;
            tx_cnt_ff[c] <= '0;
         end
      end
      else
      begin
         for (int c = 0; c < NCH; c++)
         begin
            rx_wp_ff[c]  <= rx_wp_ff[c] + AW'(rx_in[c]);
            rx_rp_ff[c]  <= rx_rp_ff[c] + AW'(rx_pop[c]);
            rx_cnt_ff[c] <= nxt_rx_cnt[c];
            tx_wp_ff[c]  <= tx_wp_ff[c] + AW'(tx_in[c]);
            tx_rp_ff[c]  <= nxt_tx_rp[c];
            tx_cnt_ff[c] <= nxt_tx_cnt[c];
         end
      end
   end

   // room and head are taken from next state so a push never meets a full queue
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         rx_room_ff  <= '0;
         tx_valid_ff <= '0;
         tx_data_ff  <= '0;
      end
      else
      begin
         for (int c = 0; c < NCH; c++)
         begin
            rx_room_ff[c]  <= nxt_rx_cnt[c] != CNT_FULL;
            tx_valid_ff[c] <= nxt_tx_cnt[c] != '0;
            if (tx_in[c] && tx_wp_ff[c] == nxt_tx_rp[c])
               tx_data_ff[c] <= bus_wdata;
            else
               tx_data_ff[c] <= txq_ff[c][nxt_tx_rp[c]];
         end
      end
   end

   // set wins over clear for every sticky bit
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         for (int c = 0; c < NCH; c++)
         begin
            sticky_ff[c] <= '0;
            flow_ff[c]   <= '0;
            err_ff[c]    <= '0;
            brk_d_ff[c]  <= 1'b0;
         end
      end
      else
      begin
         for (int c = 0; c < NCH; c++)
         begin
            sticky_ff[c] <= stk_set[c] | (sticky_ff[c] & ~stk_clr[c]);
            if (hit(rd_loc, OFF_FLOW, c))
               flow_ff[c] <= flow_hit[c];
            else
               flow_ff[c] <= flow_ff[c] | flow_hit[c];
            if (cmd_hit(CMD_RST_ERR, c))
               err_ff[c] <= rx_in[c] ? rx_entry[c][10:8] : 3'h0;
            else if (rx_in[c])
               err_ff[c] <= err_ff[c] | rx_entry[c][10:8];
            brk_d_ff[c] <= rx_break[c];
         end
      end
   end

   // counts bit times since the last push or read, stops one past the limit
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         for (int c = 0; c < NCH; c++)
            wd_ff[c] <= '0;
      end
      else
      begin
         for (int c = 0; c < NCH; c++)
         begin
            if (wd_ev[c])
               wd_ff[c] <= '0;
            else if (mode_ff[c][MB_WD_EN] && bit_tick[c] && wd_ff[c] != WD_TOP)
               wd_ff[c] <= wd_ff[c] + WW'(1);
         end
      end
   end

   // pin edges are only looked at after two flops
   // arm keeps a pin that idles high from faking an edge after reset
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         pin_arm_ff <= '0;
         for (int c = 0; c < NCH; c++)
         begin
            pin_s1_ff[c] <= '0;
            pin_s2_ff[c] <= '0;
            pin_s3_ff[c] <= '0;
         end
      end
      else
      begin
         pin_arm_ff <= {pin_arm_ff[1:0], 1'b1};
         for (int c = 0; c < NCH; c++)
         begin
            pin_s1_ff[c] <= {change_input_one[c], change_input_zero[c]};
            pin_s2_ff[c] <= pin_s1_ff[c];
            pin_s3_ff[c] <= pin_s2_ff[c];
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         for (int c = 0; c < NCH; c++)
         begin
            mask_ff[c] <= MASK_RST;
            mode_ff[c] <= MODE_RST;
            for (int k = 0; k < 4; k++)
               bid_ff[c][k] <= BID_RST;
            for (int k = 0; k < 3; k++)
               cmp_ff[c][k] <= CMP_RST;
         end
      end
      else
      begin
         for (int c = 0; c < NCH; c++)
         begin
            if (hit(wr_loc, OFF_IMR, c))
               mask_ff[c] <= bus_wdata & 8'hF7;
            if (hit(wr_loc, OFF_MODE, c))
               mode_ff[c] <= bus_wdata;
            for (int k = 0; k < 4; k++)
               if (hit(wr_loc, OFF_BID0 + 4'(k), c))
                  bid_ff[c][k] <= bus_wdata[2:0];
            for (int k = 0; k < 3; k++)
               if (hit(wr_loc, OFF_CMP0 + 4'(k), c))
                  cmp_ff[c][k] <= bus_wdata;
         end
      end
   end

   always_comb
   begin
      nxt_rd_data = '0;
      if (rd_glob)
         nxt_rd_data = rxq_ff[sel_ch][rx_rp_ff[sel_ch]];
      else if (rd_loc)
      begin
         case (sel_reg)
            OFF_ISR:
               if (mode_ff[sel_ch][MB_MREAD])
                  nxt_rd_data = RD_W'(isr_now[sel_ch] & mask_ff[sel_ch]);
               else
                  nxt_rd_data = RD_W'(isr_now[sel_ch]);
            OFF_IMR:  nxt_rd_data = RD_W'(mask_ff[sel_ch]);
            OFF_RXQ:  nxt_rd_data = rxq_ff[sel_ch][rx_rp_ff[sel_ch]];
            OFF_MODE: nxt_rd_data = RD_W'(mode_ff[sel_ch]);
            OFF_FLOW: nxt_rd_data = RD_W'({flow_ff[sel_ch], 6'h00});
            OFF_PINS: nxt_rd_data = RD_W'(pin_s2_ff[sel_ch]);
            OFF_CSR:
               if (mode_ff[sel_ch][MB_BLOCK])
                  nxt_rd_data = RD_W'({err_ff[sel_ch], 3'h0,
                                       rx_cnt_ff[sel_ch] == CNT_FULL,
                                       rx_cnt_ff[sel_ch] != '0});
               else
                  nxt_rd_data = RD_W'({rxq_ff[sel_ch][rx_rp_ff[sel_ch]][10:8], 3'h0,
                                       rx_cnt_ff[sel_ch] == CNT_FULL,
                                       rx_cnt_ff[sel_ch] != '0});
            4'h4, 4'h5, 4'h6, 4'h7:
               nxt_rd_data = RD_W'(bid_ff[sel_ch][sel_reg[1:0]]);
            4'h8, 4'h9, 4'hA:
               nxt_rd_data = RD_W'(cmp_ff[sel_ch][sel_reg[1:0]]);
            default: nxt_rd_data = '0;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         rd_data_ff               <= '0;
         interrupt_request_low_ff <= 1'b1;
      end
      else
      begin
         rd_data_ff               <= nxt_rd_data;
         interrupt_request_low_ff <= !any_req;
      end
   end

   sequence s_cmd0(logic [4:0] code);
      wr_loc && sel_reg == OFF_CMD && sel_ch == '0 && bus_wdata[7:3] == code;
   endsequence

   sequence s_isr_rd0;
      rd_loc && sel_reg == OFF_ISR && sel_ch == '0;
   endsequence

   AST_IRQ_FOLLOWS: assert property (@(posedge clk_sys) disable iff (rst)
      (isr_now[0] & mask_ff[0]) == 8'h00 && mask_ff[1] == 8'h00
      && mask_ff[2] == 8'h00 && mask_ff[3] == 8'h00 |=> interrupt_request_low_ff)
      else $error("masked source reached the request");
   AST_IRQ_LOW: assert property (@(posedge clk_sys) disable iff (rst)
      (isr_now[0][1] && mask_ff[0][1]) |=> !interrupt_request_low_ff)
      else $error("unmasked source did not pull request low");
   AST_MREAD: assert property (@(posedge clk_sys) disable iff (rst)
      s_isr_rd0 ##0 mode_ff[0][MB_MREAD]
      |=> rd_data_ff[7:0] == $past(isr_now[0] & mask_ff[0]))
      else $error("masked read wrong");
   AST_ISR3_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
      s_isr_rd0 |=> rd_data_ff[3] == 1'b0)
      else $error("reserved status bit read as one");
   AST_PIN_SET: assert property (@(posedge clk_sys) disable iff (rst)
      pin_arm_ff[2] && pin_s2_ff[0] != pin_s3_ff[0] |=> sticky_ff[0][SB_PIN])
      else $error("pin change missed");
   AST_WD_SET: assert property (@(posedge clk_sys) disable iff (rst)
      (wd_ff[0] == WD_TOP && !wd_ev[0]) ##1 !wd_ev[0] |-> sticky_ff[0][SB_WD])
      else $error("watchdog status not set");
   AST_WD_CLR: assert property (@(posedge clk_sys) disable iff (rst)
      rx_in[0] |=> !sticky_ff[0][SB_WD] && wd_ff[0] == '0)
      else $error("watchdog status not cleared by push");
   AST_ADDR_CLR: assert property (@(posedge clk_sys) disable iff (rst)
      s_cmd0(CMD_RST_ADDR) ##0 !stk_set[0][SB_ADDR] |=> !sticky_ff[0][SB_ADDR])
      else $error("address status not cleared");
   AST_BRK_CLR: assert property (@(posedge clk_sys) disable iff (rst)
      s_cmd0(CMD_RST_BRK) ##0 !stk_set[0][SB_BRK] |=> !sticky_ff[0][SB_BRK])
      else $error("break status not cleared");
   AST_FLOW_SET: assert property (@(posedge clk_sys) disable iff (rst)
      rx_in[0] && rx_entry[0].data == cmp_ff[0][1] |=> sticky_ff[0][SB_FLOW]
      && flow_ff[0][0])
      else $error("pause character not flagged");
   AST_RX_EMPTY: assert property (@(posedge clk_sys) disable iff (rst)
      rx_cnt_ff[0] == '0 |-> !isr_now[0][1])
      else $error("empty receive queue requests service");
   AST_TX_DEF: assert property (@(posedge clk_sys) disable iff (rst)
      mode_ff[0][1:0] == 2'h0 && tx_cnt_ff[0] != '0 |-> !isr_now[0][0])
      else $error("transmit ready with data queued");
   AST_RX_FULL: assert property (@(posedge clk_sys) disable iff (rst)
      rx_cnt_ff[0] == CNT_FULL && !rx_pop[0] |=> rx_cnt_ff[0] == CNT_FULL && !rx_room_ff[0])
      else $error("full receive queue changed without a read");

endmodule // qsi_core

// >>> qsi_pkg.sv
// shared constants and carrier types for the channel interrupt status block
// assumes an 8-bit register port with an 11-bit read path

package qsi_pkg;

   localparam int RD_W = 11;

   // register index inside one channel page
   localparam logic [3:0] OFF_ISR   = 4'h0;
   localparam logic [3:0] OFF_IMR   = 4'h1;
   localparam logic [3:0] OFF_RXQ   = 4'h2;
   localparam logic [3:0] OFF_TXQ   = 4'h3;
   localparam logic [3:0] OFF_BID0  = 4'h4;
   localparam logic [3:0] OFF_CMP0  = 4'h8;
   localparam logic [3:0] OFF_CMD   = 4'hB;
   localparam logic [3:0] OFF_CSR   = 4'hC;
   localparam logic [3:0] OFF_MODE  = 4'hD;
   localparam logic [3:0] OFF_FLOW  = 4'hE;
   localparam logic [3:0] OFF_PINS  = 4'hF;

   // address page in bus_addr[7:6]
   localparam logic [1:0] PAGE_LOCAL  = 2'h0;
   localparam logic [1:0] PAGE_GLOBAL = 2'h1;

   // reset values
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [2:0] BID_RST  = 3'h0;
   localparam logic [7:0] CMP_RST  = 8'h00;

   // mode word bits
   localparam int MB_WD_EN = 7;
   localparam int MB_MREAD = 6;
   localparam int MB_BLOCK = 5;
   localparam int MB_RXT   = 2;
   localparam int MB_TXT   = 0;

   // command codes in command_register[7:3]
   localparam logic [4:0] CMD_RST_ERR  = 5'h04;
   localparam logic [4:0] CMD_RST_BRK  = 5'h05;
   localparam logic [4:0] CMD_RST_ADDR = 5'h1B;

   // sticky bit slots: {pin, watchdog, address, flow, break}
   localparam int SB_BRK  = 0;
   localparam int SB_FLOW = 1;
   localparam int SB_ADDR = 2;
   localparam int SB_WD   = 3;
   localparam int SB_PIN  = 4;

   localparam int WDOG_BIT_TIMES = 64;

   typedef struct packed {
      logic       brk;
      logic       fe;
      logic       pe;
      logic [7:0] data;
   } qsi_rx_ent_t;

endpackage

// >>> qsi_host.sv
// host processor model for the channel register port
// assumes one clock; strobes change by nba right after a rising edge
`timescale 1ns/1ps

module qsi_host
   import qsi_pkg::*;
(
   input  wire logic            clk_sys,
   input  wire logic [RD_W-1:0] rd_data,
   output logic      [7:0]      bus_addr,
   output logic      [7:0]      bus_wdata,
   output logic                 bus_wr,
   output logic                 bus_rd
);
   initial
   begin
      bus_addr  = 8'h00;
      bus_wdata = 8'h00;
      bus_wr    = 1'b0;
      bus_rd    = 1'b0;
   end

   // one-cycle write; also carries the clear commands
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus_addr  <= a;
      bus_wdata <= d;
      bus_wr    <= 1'b1;
      @(posedge clk_sys);
      bus_wr    <= 1'b0;
   endtask

   // data taken in the one cycle after the strobe; status read first
   task automatic rd(input logic [7:0] a, output logic [RD_W-1:0] d);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_rd   <= 1'b1;
      @(posedge clk_sys);
      bus_rd   <= 1'b0;
      #1 d = rd_data;
   endtask
endmodule // qsi_host

// >>> qsi_core_bench.sv
// self-checking bench for the channel interrupt status block, channel 0
// assumes the host model drives the register port; watchdog shortened to 4
`timescale 1ns/1ps

module qsi_core_bench
   import qsi_pkg::*;
   ;
   logic                  clk_sys;
   logic                  rst;
   logic [7:0]            bus_addr;
   logic [7:0]            bus_wdata;
   logic                  bus_wr;
   logic                  bus_rd;
   logic [RD_W-1:0]       rd_data;
   logic [3:0]            rx_push;
   qsi_rx_ent_t [3:0]     rx_entry;
   logic [3:0]            rx_addr_seen;
   logic [3:0]            rx_break;
   logic [3:0]            bit_tick;
   logic [3:0]            tx_pop;
   logic [3:0]            pin0;
   logic [3:0]            pin1;
   logic [3:0]            rx_room;
   logic [3:0]            tx_valid;
   logic [3:0][7:0]       tx_data;
   logic                  irq_low;
   int                    error_cnt;
   int                    n_tests;
   int                    cyc;
   logic [RD_W-1:0]       d;

   qsi_host u_qsi_host (.clk_sys(clk_sys), .rd_data(rd_data), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd));

   // short watchdog keeps the run brief
   qsi_core #(.WDOG_BITS(4)) u_qsi_core (.clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .rd_data_ff(rd_data),
      .rx_push(rx_push), .rx_entry(rx_entry), .rx_addr_seen(rx_addr_seen),
      .rx_break(rx_break), .bit_tick(bit_tick), .tx_pop(tx_pop),
      .change_input_zero(pin0), .change_input_one(pin1), .rx_room_ff(rx_room),
      .tx_valid_ff(tx_valid), .tx_data_ff(tx_data), .interrupt_request_low_ff(irq_low));

   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   task end_of_test;
      $display("tests %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task chk(input logic [RD_W-1:0] got, input logic [RD_W-1:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // interrupt line has a one-cycle lag, so settle first
   task chk_irq(input logic exp);
      repeat (2) @(posedge clk_sys);
      #1;
      n_tests++;
      if (irq_low !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: request line %b", $time, irq_low);
      end
   endtask

   task rdc(input logic [7:0] a, input logic [RD_W-1:0] exp);
      u_qsi_host.rd(a, d);
      chk(d, exp);
   endtask

   task push(input logic [10:0] e);
      @(posedge clk_sys);
      rx_push[0]  <= 1'b1;
      rx_entry[0] <= e;
      @(posedge clk_sys);
      rx_push[0]  <= 1'b0;
   endtask

   task ticks(input int n);
      @(posedge clk_sys);
      bit_tick[0] <= 1'b1;
      repeat (n) @(posedge clk_sys);
      bit_tick[0] <= 1'b0;
   endtask

   task t_reset;
      rdc({4'h0, OFF_IMR}, {3'h0, MASK_RST});
      rdc({4'h0, OFF_ISR}, 11'h001);
      chk_irq(1'b1);
      rdc(8'h80, 11'h000);
      $display("reset test done");
   endtask

   task t_rx;
      push(11'h5A5);
      rdc({4'h0, OFF_ISR}, 11'h003);
      rdc({4'h0, OFF_CSR}, 11'h0A1);
      u_qsi_host.wr({4'h0, OFF_IMR}, 8'h02);
      chk_irq(1'b0);
      u_qsi_host.wr({4'h0, OFF_MODE}, 8'h40);
      rdc({4'h0, OFF_ISR}, 11'h002);
      rdc({4'h0, OFF_RXQ}, 11'h5A5);
      rdc({4'h0, OFF_ISR}, 11'h000);
      chk_irq(1'b1);
      u_qsi_host.wr({4'h0, OFF_MODE}, 8'h00);
      u_qsi_host.wr({4'h0, OFF_IMR}, 8'hFF);
      rdc({4'h0, OFF_IMR}, 11'h0F7);
      chk_irq(1'b0);
      u_qsi_host.wr({4'h0, OFF_IMR}, 8'h00);
      $display("receive ready test done");
   endtask

   task t_events;
      rx_break[0] <= 1'b1;
      rdc({4'h0, OFF_ISR}, 11'h005);
      u_qsi_host.wr({4'h0, OFF_CMD}, {CMD_RST_BRK, 3'h0});
      rx_break[0] <= 1'b0;
      rdc({4'h0, OFF_ISR}, 11'h005);
      u_qsi_host.wr({4'h0, OFF_CMD}, {CMD_RST_BRK, 3'h0});
      rdc({4'h0, OFF_ISR}, 11'h001);
      pin0[0] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rdc({4'h0, OFF_ISR}, 11'h081);
      rdc({4'h0, OFF_PINS}, 11'h001);
      rdc({4'h0, OFF_ISR}, 11'h001);
      $display("event test done");
   endtask

   task t_wdog;
      u_qsi_host.wr({4'h0, OFF_MODE}, 8'h80);
      push(11'h011);
      rdc({4'h0, OFF_RXQ}, 11'h011);
      ticks(3);
      rdc({4'h0, OFF_ISR}, 11'h001);
      ticks(3);
      rdc({4'h0, OFF_ISR}, 11'h041);
      push(11'h022);
      rdc({4'h0, OFF_ISR}, 11'h003);
      ticks(6);
      rdc({4'h0, OFF_ISR}, 11'h043);
      rdc(8'h42, 11'h022);
      rdc({4'h0, OFF_ISR}, 11'h001);
      u_qsi_host.wr({4'h0, OFF_MODE}, 8'h00);
      $display("watchdog test done");
   endtask

   task t_fifo;
      u_qsi_host.wr({4'h0, OFF_TXQ}, 8'h3C);
      rdc({4'h0, OFF_ISR}, 11'h000);
      chk({2'h0, tx_valid[0], tx_data[0]}, 11'h13C);
      @(posedge clk_sys);
      tx_pop[0] <= 1'b1;
      @(posedge clk_sys);
      tx_pop[0] <= 1'b0;
      rdc({4'h0, OFF_ISR}, 11'h001);
      u_qsi_host.wr({4'h0, OFF_MODE}, 8'h04);
      repeat (7) push(11'h055);
      rdc({4'h0, OFF_ISR}, 11'h001);
      push(11'h055);
      rdc({4'h0, OFF_ISR}, 11'h003);
      repeat (8) u_qsi_host.rd({4'h0, OFF_RXQ}, d);
      rdc({4'h0, OFF_ISR}, 11'h001);
      $display("queue level test done");
   endtask

   task t_chars;
      u_qsi_host.wr({4'h0, OFF_MODE}, 8'h20);
      u_qsi_host.wr({4'h0, OFF_CMD}, {CMD_RST_ERR, 3'h0});
      u_qsi_host.wr(8'h08, 8'h11);
      u_qsi_host.wr(8'h09, 8'h13);
      u_qsi_host.wr(8'h0A, 8'h42);
      u_qsi_host.wr(8'h05, 8'hFF);
      rdc(8'h05, 11'h007);
      rdc(8'h0A, 11'h042);
      push(11'h213);
      rdc({4'h0, OFF_ISR}, 11'h013);
      push(11'h111);
      rdc({4'h0, OFF_FLOW}, 11'h0C0);
      rdc({4'h0, OFF_ISR}, 11'h003);
      rdc({4'h0, OFF_CSR}, 11'h061);
      u_qsi_host.wr({4'h0, OFF_CMD}, {CMD_RST_ERR, 3'h0});
      rdc({4'h0, OFF_CSR}, 11'h001);
      @(posedge clk_sys);
      rx_entry[0]     <= 11'h042;
      rx_addr_seen[0] <= 1'b1;
      @(posedge clk_sys);
      rx_addr_seen[0] <= 1'b0;
      rdc({4'h0, OFF_ISR}, 11'h023);
      u_qsi_host.wr({4'h0, OFF_CMD}, {CMD_RST_ADDR, 3'h0});
      rdc({4'h0, OFF_ISR}, 11'h003);
      rdc({4'h0, OFF_RXQ}, 11'h213);
      rdc({4'h0, OFF_RXQ}, 11'h111);
      $display("character compare test done");
   endtask

   // a push into a full queue must be dropped, so one read leaves it not full
   task t_full;
      u_qsi_host.wr({4'h0, OFF_MODE}, 8'h0C);
      repeat (16) push(11'h0AA);
      rdc({4'h0, OFF_ISR}, 11'h003);
      chk({10'h000, rx_room[0]}, 11'h000);
      push(11'h0BB);
      rdc({4'h0, OFF_RXQ}, 11'h0AA);
      rdc({4'h0, OFF_ISR}, 11'h001);
      chk({10'h000, rx_room[0]}, 11'h001);
      $display("full trigger test done");
   endtask

   // hang guard: whole run needs well under a thousand cycles
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         error_cnt++;
         end_of_test;
      end
   end

   initial
   begin
      {rst, rx_push, rx_addr_seen, rx_break, bit_tick, tx_pop, pin0, pin1} = '1;
      {rx_push, rx_addr_seen, rx_break, bit_tick, tx_pop, pin0, pin1} = '0;
      rx_entry  = '0;
      error_cnt = 0;
      n_tests   = 0;
      cyc       = 0;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset();
      t_rx();
      t_events();
      t_wdog();
      t_fifo();
      t_chars();
      t_full();
      end_of_test;
   end
endmodule // qsi_core_bench
